// >>> dlfr_map.svh
// register map, field positions and reset values of the layer frame regs
//------------------------------------------------------------------------
//------------------------------------------------------------------------
`ifndef DLFR_MAP_SVH
`define DLFR_MAP_SVH

// register indices, byte address is four times the index
`define DLFR_IDX_CON_MODE   10'h020
`define DLFR_IDX_CON_ORG    10'h024
`define DLFR_IDX_CON_DISP   10'h028
`define DLFR_IDX_CON_X      10'h02C
`define DLFR_IDX_CON_Y      10'h02E
`define DLFR_IDX_WIN_MODE   10'h030
`define DLFR_IDX_WIN_ORG    10'h034
`define DLFR_IDX_WIN_DISP   10'h038
`define DLFR_IDX_STATUS     10'h03C
`define DLFR_IDX_ML_MODE    10'h040
`define DLFR_IDX_ML_ORG0    10'h044
`define DLFR_IDX_ML_DISP0   10'h048
`define DLFR_IDX_ML_ORG1    10'h04C
`define DLFR_IDX_ML_DISP1   10'h050
`define DLFR_IDX_ML_X       10'h054
`define DLFR_IDX_ML_Y       10'h056
`define DLFR_IDX_MR_MODE    10'h058

// field positions
`define DLFR_FMT_BIT        31
`define DLFR_FLIP_HI        30
`define DLFR_FLIP_LO        29
`define DLFR_WIDTH_HI       23
`define DLFR_WWIDTH_HI      21
`define DLFR_WIDTH_LO       16
`define DLFR_HEIGHT_HI      11
`define DLFR_ADDR_HI        25
`define DLFR_ORG_LO         4
`define DLFR_POS_HI         11

// reset values and unit shifts
`define DLFR_RST_ADDR       26'h0000000
`define DLFR_RST_POS        12'h000
`define DLFR_UNIT_SHIFT     6

`endif

// >>> dlfr_pkg.sv
// types shared by the layer frame register bank
package dlfr_pkg;
	typedef logic [25:0] dlfr_addr_t;
	typedef logic [11:0] dlfr_pos_t;
	typedef enum logic [1:0] {
		DLFR_FLIP_F0  = 2'b00,
		DLFR_FLIP_F1  = 2'b01,
		DLFR_FLIP_ALT = 2'b10,
		DLFR_FLIP_RSV = 2'b11
	} dlfr_flip_t;
endpackage : dlfr_pkg

// >>> dlfr_regs.sv
// layer frame register bank with apb slave and fetch parameter outputs
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`include "dlfr_map.svh"

module dlfr_regs (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// display timing
	input  wire logic              frame_boundary,
	// console layer
	output dlfr_pkg::dlfr_addr_t   console_origin,
	output dlfr_pkg::dlfr_addr_t   console_fetch,
	output dlfr_pkg::dlfr_pos_t    console_x,
	output dlfr_pkg::dlfr_pos_t    console_y,
	output logic                   console_pixel_format,
	output logic      [13:0]       console_width_bytes,
	output logic      [12:0]       console_height,
	// window layer
	output dlfr_pkg::dlfr_addr_t   window_origin,
	output dlfr_pkg::dlfr_addr_t   window_fetch,
	output logic                   window_pixel_format,
	output logic      [11:0]       window_memory_width,
	// middle-left layer
	output dlfr_pkg::dlfr_addr_t   middle_left_origin,
	output dlfr_pkg::dlfr_addr_t   middle_left_fetch,
	output dlfr_pkg::dlfr_pos_t    middle_left_x,
	output dlfr_pkg::dlfr_pos_t    middle_left_y,
	output logic                   middle_left_pixel_format,
	output logic      [13:0]       middle_left_width,
	output logic      [12:0]       middle_left_height,
	output logic                   middle_left_frame,
	// middle-right layer
	output logic                   middle_right_pixel_format,
	output logic      [13:0]       middle_right_width,
	output logic      [12:0]       middle_right_height,
	output logic                   middle_right_frame
);
	import dlfr_pkg::*;

	//--------------------------------------------------------------
	// storage
	//--------------------------------------------------------------
	logic                 con_fmt;
	logic        [7:0]    con_w;
	logic        [11:0]   con_h;
	logic        [21:0]   con_org;
	dlfr_addr_t           con_disp;
	dlfr_pos_t            con_x;
	dlfr_pos_t            con_y;
	logic                 win_fmt;
	logic        [5:0]    win_w;
	logic        [21:0]   win_org;
	logic        [24:0]   win_disp;
	dlfr_pos_t            ml_x;
	dlfr_pos_t            ml_y;
	logic                 mid_fmt   [2];
	dlfr_flip_t           mid_flip  [2];
	logic        [7:0]    mid_w     [2];
	logic        [11:0]   mid_h     [2];
	logic                 mid_frame [2];
	logic        [21:0]   ml_org    [2];
	dlfr_addr_t           ml_disp   [2];
	logic        [13:0]   mid_wb    [2];
	logic        [12:0]   mid_hr    [2];

	//--------------------------------------------------------------
	// apb decode
	//--------------------------------------------------------------
	logic        [9:0]    idx;
	logic        [31:0]   next_prdata;
	logic                 next_pslverr;
	logic                 wr_en;

	assign idx = paddr[11:2];
	// commit only at the completing edge, so a held request writes once
	assign wr_en = psel & penable & pready & pwrite & ~next_pslverr;

	// read mux, reserved bits stay zero
	always_comb begin
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		case (idx)
			`DLFR_IDX_CON_MODE: begin
				next_prdata = {con_fmt, 7'h00, con_w, 4'h0, con_h};
			end
			`DLFR_IDX_CON_ORG: begin
				next_prdata = {6'h00, con_org, 4'h0};
			end
			`DLFR_IDX_CON_DISP: begin
				next_prdata = {6'h00, con_disp[25:1],
					con_disp[0] & ~con_fmt};
			end
			`DLFR_IDX_CON_X: begin
				next_prdata = {20'h00000, con_x};
			end
			`DLFR_IDX_CON_Y: begin
				next_prdata = {20'h00000, con_y};
			end
			`DLFR_IDX_WIN_MODE: begin
				next_prdata = {win_fmt, 9'h000, win_w, 16'h0000};
			end
			`DLFR_IDX_WIN_ORG: begin
				next_prdata = {6'h00, win_org, 4'h0};
			end
			`DLFR_IDX_WIN_DISP: begin
				next_prdata = {6'h00, win_disp, 1'b0};
			end
			`DLFR_IDX_STATUS: begin
				next_prdata = {30'h0000_0000, mid_frame[1],
					mid_frame[0]};
			end
			`DLFR_IDX_ML_MODE: begin
				next_prdata = {mid_fmt[0], mid_flip[0], 5'h00,
					mid_w[0], 4'h0, mid_h[0]};
			end
			`DLFR_IDX_ML_ORG0: begin
				next_prdata = {6'h00, ml_org[0], 4'h0};
			end
			`DLFR_IDX_ML_DISP0: begin
				next_prdata = {6'h00, ml_disp[0][25:1],
					ml_disp[0][0] & ~mid_fmt[0]};
			end
			`DLFR_IDX_ML_ORG1: begin
				next_prdata = {6'h00, ml_org[1], 4'h0};
			end
			`DLFR_IDX_ML_DISP1: begin
				next_prdata = {6'h00, ml_disp[1][25:1],
					ml_disp[1][0] & ~mid_fmt[0]};
			end
			`DLFR_IDX_ML_X: begin
				next_prdata = {20'h00000, ml_x};
			end
			`DLFR_IDX_ML_Y: begin
				next_prdata = {20'h00000, ml_y};
			end
			`DLFR_IDX_MR_MODE: begin
				next_prdata = {mid_fmt[1], mid_flip[1], 5'h00,
					mid_w[1], 4'h0, mid_h[1]};
			end
			default: begin
				next_pslverr = 1'b1;
			end
		endcase
		// misaligned byte addresses map to nothing
		if (paddr[1:0] != 2'b00) begin
			next_prdata  = 32'h0000_0000;
			next_pslverr = 1'b1;
		end
	end

	// one wait state: answer is prepared in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			prdata  <= (psel & penable & ~pready & ~pwrite) ?
				next_prdata : 32'h0000_0000;
			pslverr <= psel & penable & ~pready & next_pslverr;
		end
	end

	//--------------------------------------------------------------
	// console, window and middle-left position registers
	//--------------------------------------------------------------
	// only documented fields are taken from the write data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			con_fmt  <= 1'b0;
			con_w    <= 8'h00;
			con_h    <= 12'h000;
			con_org  <= 22'h000000;
			con_disp <= `DLFR_RST_ADDR;
			con_x    <= `DLFR_RST_POS;
			con_y    <= `DLFR_RST_POS;
		end else if (wr_en) begin
			case (idx)
				`DLFR_IDX_CON_MODE: begin
					con_fmt <= pwdata[`DLFR_FMT_BIT];
					con_w   <= pwdata[`DLFR_WIDTH_HI:`DLFR_WIDTH_LO];
					con_h   <= pwdata[`DLFR_HEIGHT_HI:0];
				end
				`DLFR_IDX_CON_ORG: begin
					con_org <= pwdata[`DLFR_ADDR_HI:`DLFR_ORG_LO];
				end
				`DLFR_IDX_CON_DISP: begin
					con_disp <= pwdata[`DLFR_ADDR_HI:0];
				end
				`DLFR_IDX_CON_X: begin
					con_x <= pwdata[`DLFR_POS_HI:0];
				end
				`DLFR_IDX_CON_Y: begin
					con_y <= pwdata[`DLFR_POS_HI:0];
				end
				default: begin
					con_fmt <= con_fmt;
				end
			endcase
		end
	end

	// window stores no bit 0 of its start at all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_fmt  <= 1'b0;
			win_w    <= 6'h00;
			win_org  <= 22'h000000;
			win_disp <= 25'h0000000;
			ml_x     <= `DLFR_RST_POS;
			ml_y     <= `DLFR_RST_POS;
		end else if (wr_en) begin
			case (idx)
				`DLFR_IDX_WIN_MODE: begin
					win_fmt <= pwdata[`DLFR_FMT_BIT];
					win_w   <= pwdata[`DLFR_WWIDTH_HI:`DLFR_WIDTH_LO];
				end
				`DLFR_IDX_WIN_ORG: begin
					win_org <= pwdata[`DLFR_ADDR_HI:`DLFR_ORG_LO];
				end
				`DLFR_IDX_WIN_DISP: begin
					win_disp <= pwdata[`DLFR_ADDR_HI:1];
				end
				`DLFR_IDX_ML_X: begin
					ml_x <= pwdata[`DLFR_POS_HI:0];
				end
				`DLFR_IDX_ML_Y: begin
					ml_y <= pwdata[`DLFR_POS_HI:0];
				end
				default: begin
					win_fmt <= win_fmt;
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// middle layers, one instance of logic per layer
	//--------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_mid
			localparam logic [9:0] MODE_IDX = (g == 0) ?
				`DLFR_IDX_ML_MODE : `DLFR_IDX_MR_MODE;
			localparam logic [9:0] ORG_IDX = (g == 0) ?
				`DLFR_IDX_ML_ORG0 : `DLFR_IDX_ML_ORG1;
			localparam logic [9:0] DISP_IDX = (g == 0) ?
				`DLFR_IDX_ML_DISP0 : `DLFR_IDX_ML_DISP1;

			// mode fields of this middle layer
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mid_fmt[g]  <= 1'b0;
					mid_flip[g] <= DLFR_FLIP_F0;
					mid_w[g]    <= 8'h00;
					mid_h[g]    <= 12'h000;
				end else if (wr_en && idx == MODE_IDX) begin
					mid_fmt[g]  <= pwdata[`DLFR_FMT_BIT];
					mid_flip[g] <= dlfr_flip_t'(
						pwdata[`DLFR_FLIP_HI:`DLFR_FLIP_LO]);
					mid_w[g] <= pwdata[`DLFR_WIDTH_HI:`DLFR_WIDTH_LO];
					mid_h[g] <= pwdata[`DLFR_HEIGHT_HI:0];
				end
			end

			// frame g address pair of the middle-left layer
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ml_org[g]  <= 22'h000000;
					ml_disp[g] <= `DLFR_RST_ADDR;
				end else if (wr_en && idx == ORG_IDX) begin
					ml_org[g] <= pwdata[`DLFR_ADDR_HI:`DLFR_ORG_LO];
				end else if (wr_en && idx == DISP_IDX) begin
					ml_disp[g] <= pwdata[`DLFR_ADDR_HI:0];
				end
			end

			// shown frame moves only on the boundary pulse, so a
			// new flip code never tears the frame in progress
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mid_frame[g] <= 1'b0;
				end else if (frame_boundary) begin
					case (mid_flip[g])
						DLFR_FLIP_F0: begin
							mid_frame[g] <= 1'b0;
						end
						DLFR_FLIP_F1: begin
							mid_frame[g] <= 1'b1;
						end
						DLFR_FLIP_ALT: begin
							mid_frame[g] <= ~mid_frame[g];
						end
						default: begin
							mid_frame[g] <= mid_frame[g];
						end
					endcase
				end
			end

			// width in bytes and height in rasters for the fetch
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mid_wb[g] <= 14'h0000;
					mid_hr[g] <= 13'h0000;
				end else begin
					mid_wb[g] <= {mid_w[g], 6'h00};
					mid_hr[g] <= {1'b0, mid_h[g]} + 13'h0001;
				end
			end
		end
	endgenerate

	//--------------------------------------------------------------
	// fetch parameter outputs
	//--------------------------------------------------------------
	assign middle_left_width         = mid_wb[0];
	assign middle_left_height        = mid_hr[0];
	assign middle_left_frame         = mid_frame[0];
	assign middle_right_width        = mid_wb[1];
	assign middle_right_height       = mid_hr[1];
	assign middle_right_frame        = mid_frame[1];

	// console and window outputs, one cycle behind the registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			console_origin       <= `DLFR_RST_ADDR;
			console_fetch        <= `DLFR_RST_ADDR;
			console_x            <= `DLFR_RST_POS;
			console_y            <= `DLFR_RST_POS;
			console_pixel_format <= 1'b0;
			console_width_bytes  <= 14'h0000;
			console_height       <= 13'h0000;
			window_origin        <= `DLFR_RST_ADDR;
			window_fetch         <= `DLFR_RST_ADDR;
			window_pixel_format  <= 1'b0;
			window_memory_width  <= 12'h000;
		end else begin
			console_origin <= {con_org, 4'h0};
			console_fetch  <= {con_disp[25:1],
				con_disp[0] & ~con_fmt};
			console_x <= con_x;
			console_y <= con_y;
			console_pixel_format <= con_fmt;
			console_width_bytes  <= {con_w, 6'h00};
			console_height       <= {1'b0, con_h} + 13'h0001;
			window_origin <= {win_org, 4'h0};
			window_fetch  <= {win_disp, 1'b0};
			window_pixel_format <= win_fmt;
			window_memory_width <= {win_w, 6'h00};
		end
	end

	// middle-left fetch pair follows the shown frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			middle_left_origin        <= `DLFR_RST_ADDR;
			middle_left_fetch         <= `DLFR_RST_ADDR;
			middle_left_x             <= `DLFR_RST_POS;
			middle_left_y             <= `DLFR_RST_POS;
			middle_left_pixel_format  <= 1'b0;
			middle_right_pixel_format <= 1'b0;
		end else begin
			middle_left_origin <= {ml_org[mid_frame[0]], 4'h0};
			middle_left_fetch  <= {ml_disp[mid_frame[0]][25:1],
				ml_disp[mid_frame[0]][0] & ~mid_fmt[0]};
			middle_left_x <= ml_x;
			middle_left_y <= ml_y;
			middle_left_pixel_format  <= mid_fmt[0];
			middle_right_pixel_format <= mid_fmt[1];
		end
	end

endmodule : dlfr_regs

// >>> dlfr_regs_asserts.sv
// port checks for the layer frame register bank
`timescale 1ns/10ps

module dlfr_regs_asserts (
	// clock and reset
	input wire logic                 pclk,
	input wire logic                 presetn,
	// apb handshake
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// display timing
	input wire logic                 frame_boundary,
	// fetch parameters
	input wire dlfr_pkg::dlfr_addr_t console_origin,
	input wire dlfr_pkg::dlfr_addr_t console_fetch,
	input wire logic                 console_pixel_format,
	input wire dlfr_pkg::dlfr_addr_t window_origin,
	input wire dlfr_pkg::dlfr_addr_t window_fetch,
	input wire logic [11:0]          window_memory_width,
	input wire dlfr_pkg::dlfr_addr_t middle_left_origin,
	input wire logic [13:0]          middle_left_width,
	input wire logic [12:0]          middle_left_height,
	input wire logic                 middle_left_frame
);
	import dlfr_pkg::*;

	//------------------------------------------------------------
	// checks, all in the pclk domain
	//------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// answer stands a single cycle
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	// at most one wait state in every access phase
	wait_state_a: assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered after one wait");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr seen without pready");
	origin_align_a: assert property (
		(console_origin[3:0] | window_origin[3:0]
			| middle_left_origin[3:0]) == 4'h0)
		else $error("frame origin not on a 16 byte step");
	window_lsb_a: assert property (window_fetch[0] == 1'b0)
		else $error("window display start odd");
	// format settled for a cycle so the fetch mask has landed
	direct_lsb_a: assert property (
		console_pixel_format && $past(console_pixel_format)
			|-> !console_fetch[0])
		else $error("direct colour console start odd");
	width_units_a: assert property (
		window_memory_width[5:0] == 6'h00
			&& middle_left_width[5:0] == 6'h00)
		else $error("frame width not in 64 byte units");
	height_plus_a: assert property (
		$past(presetn) |-> middle_left_height != 13'h0000)
		else $error("middle left height lost its plus one");
	frame_hold_a: assert property (
		!frame_boundary |=> $stable(middle_left_frame))
		else $error("shown frame changed off a boundary");
endmodule : dlfr_regs_asserts

// >>> dlfr_regs_bench.sv
// self-checking bench for the layer frame register bank
`timescale 1ns/10ps
`include "dlfr_map.svh"

module dlfr_regs_bench;
	import dlfr_pkg::*;
	//------------------------------------------------------------
	// signals
	//------------------------------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, frame_boundary;
	logic [11:0] paddr, window_memory_width, h;
	logic [31:0] pwdata, prdata, v;
	logic        pready, pslverr, console_pixel_format;
	logic        window_pixel_format, middle_left_pixel_format;
	logic        middle_left_frame, middle_right_pixel_format;
	logic        middle_right_frame;
	dlfr_addr_t  console_origin, console_fetch, window_origin;
	dlfr_addr_t  window_fetch, middle_left_origin, middle_left_fetch;
	dlfr_pos_t   console_x, console_y, middle_left_x, middle_left_y;
	logic [13:0] console_width_bytes, middle_left_width;
	logic [13:0] middle_right_width;
	logic [12:0] console_height, middle_left_height;
	logic [12:0] middle_right_height;
	logic [7:0]  w;
	logic [33:0] notes[$];
	logic [33:0] note;
	logic [9:0]  tidx[13];
	logic [31:0] texp[13];
	int          miscompares, num_checks, cycles, seed;

	dlfr_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .frame_boundary,
		.console_origin, .console_fetch, .console_x, .console_y,
		.console_pixel_format, .console_width_bytes, .console_height,
		.window_origin, .window_fetch, .window_pixel_format,
		.window_memory_width, .middle_left_origin, .middle_left_fetch,
		.middle_left_x, .middle_left_y, .middle_left_pixel_format,
		.middle_left_width, .middle_left_height, .middle_left_frame,
		.middle_right_pixel_format, .middle_right_width,
		.middle_right_height, .middle_right_frame);

	//------------------------------------------------------------
	// tasks
	//------------------------------------------------------------
	task automatic chk(input string s, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	// note bit 33 asks for a data compare, bit 32 is the error flag
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [33:0] n);
		notes.push_back(n);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		apb(1'b1, {i, 2'b00}, d, 34'h0);
	endtask : wr

	task automatic rd(input logic [9:0] i, input logic [31:0] e);
		apb(1'b0, {i, 2'b00}, 32'h0, {2'b10, e});
	endtask : rd

	// outputs follow a write one pclk later
	task automatic settle;
		repeat (2) @(posedge pclk);
	endtask : settle

	task automatic pulse;
		@(posedge pclk);
		frame_boundary <= 1'b1;
		@(posedge pclk);
		frame_boundary <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : pulse

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	//------------------------------------------------------------
	// clock, timeout and result monitor
	//------------------------------------------------------------
	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	// cut a hang short well past the expected run length
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			stop_test;
		end
	end

	// oldest note meets each completed transfer
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1) begin
			note = notes.pop_front();
			chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
			if (note[33])
				chk("prdata", note[31:0], prdata);
		end

	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, frame_boundary} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		seed = 80;
		presetn = 1'b0;
		tidx = '{`DLFR_IDX_CON_ORG, `DLFR_IDX_CON_DISP, `DLFR_IDX_CON_X,
			`DLFR_IDX_CON_Y, `DLFR_IDX_WIN_MODE, `DLFR_IDX_WIN_ORG,
			`DLFR_IDX_WIN_DISP, `DLFR_IDX_ML_ORG0, `DLFR_IDX_ML_DISP0,
			`DLFR_IDX_ML_ORG1, `DLFR_IDX_ML_DISP1, `DLFR_IDX_ML_X,
			`DLFR_IDX_MR_MODE};
		texp = '{32'h03FFFFF0, 32'h03FFFFFF, 32'h00000FFF, 32'h00000FFF,
			32'h803F0000, 32'h03FFFFF0, 32'h03FFFFFE, 32'h03FFFFF0,
			32'h03FFFFFF, 32'h03FFFFF0, 32'h03FFFFFF, 32'h00000FFF,
			32'hE0FF0FFF};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(`DLFR_IDX_CON_ORG, 32'h0);
		// all ones into every register but console mode, middle-left mode, status and ml_y, reserved bits drop away
		for (int k = 0; k < 13; k++)
			wr(tidx[k], 32'hFFFFFFFF);
		for (int k = 0; k < 13; k++)
			rd(tidx[k], texp[k]);
		settle;
		chk("c_org", 32'h03FFFFF0, 32'(console_origin));
		chk("c_fetch", 32'h03FFFFFF, 32'(console_fetch));
		chk("c_x", 32'h00000FFF, 32'(console_x));
		chk("c_y", 32'h00000FFF, 32'(console_y));
		chk("w_org", 32'h03FFFFF0, 32'(window_origin));
		chk("w_fetch", 32'h03FFFFFE, 32'(window_fetch));
		chk("w_width", 32'hFC0, 32'(window_memory_width));
		chk("w_fmt", 32'h1, 32'(window_pixel_format));
		$display("test reserved bits done");
		// direct colour masks the start bit, indirect brings it back
		wr(`DLFR_IDX_CON_MODE, 32'hFFFFFFFF);
		rd(`DLFR_IDX_CON_MODE, 32'h80FF0FFF);
		rd(`DLFR_IDX_CON_DISP, 32'h03FFFFFE);
		settle;
		chk("c_fetch", 32'h03FFFFFE, 32'(console_fetch));
		chk("c_fmt", 32'h1, 32'(console_pixel_format));
		chk("c_wid", 32'h3FC0, 32'(console_width_bytes));
		chk("c_hgt", 32'h1000, 32'(console_height));
		wr(`DLFR_IDX_CON_MODE, 32'h0);
		wr(`DLFR_IDX_WIN_MODE, 32'h0);
		rd(`DLFR_IDX_CON_DISP, 32'h03FFFFFF);
		rd(`DLFR_IDX_WIN_DISP, 32'h03FFFFFE);
		$display("test colour formats done");
		// random start positions
		for (int k = 0; k < 4; k++) begin
			v = $random(seed);
			wr(`DLFR_IDX_ML_X, v);
			wr(`DLFR_IDX_ML_Y, ~v);
			rd(`DLFR_IDX_ML_X, {20'h0, v[11:0]});
			rd(`DLFR_IDX_ML_Y, {20'h0, ~v[11:0]});
			settle;
			chk("ml_x", {20'h0, v[11:0]}, 32'(middle_left_x));
			chk("ml_y", {20'h0, ~v[11:0]}, 32'(middle_left_y));
		end
		// two frame pairs, flip codes take hold only at a boundary
		wr(`DLFR_IDX_ML_ORG0, 32'h100);
		wr(`DLFR_IDX_ML_DISP0, 32'h123);
		wr(`DLFR_IDX_ML_ORG1, 32'h200);
		wr(`DLFR_IDX_ML_DISP1, 32'h245);
		w = 8'($random(seed));
		h = 12'($random(seed));
		wr(`DLFR_IDX_ML_MODE, {3'b101, 5'h1F, w, 4'hF, h});
		rd(`DLFR_IDX_ML_MODE, {3'b101, 5'h0, w, 4'h0, h});
		settle;
		chk("ml_wid", {18'h0, w, 6'h0}, 32'(middle_left_width));
		chk("ml_hgt", 32'(h) + 1, 32'(middle_left_height));
		chk("ml_fmt", 32'h1, 32'(middle_left_pixel_format));
		chk("ml_frm", 32'h0, 32'(middle_left_frame));
		chk("ml_fetch", 32'h122, 32'(middle_left_fetch));
		pulse;
		chk("ml_frm", 32'h1, 32'(middle_left_frame));
		chk("ml_org", 32'h200, 32'(middle_left_origin));
		chk("ml_fetch", 32'h244, 32'(middle_left_fetch));
		wr(`DLFR_IDX_ML_MODE, {3'b010, 29'h0});
		pulse;
		chk("ml_frm", 32'h0, 32'(middle_left_frame));
		chk("ml_fetch", 32'h123, 32'(middle_left_fetch));
		pulse;
		chk("ml_frm", 32'h1, 32'(middle_left_frame));
		wr(`DLFR_IDX_ML_MODE, {3'b011, 29'h0});
		pulse;
		chk("ml_frm", 32'h1, 32'(middle_left_frame));
		wr(`DLFR_IDX_ML_MODE, 32'h0);
		pulse;
		chk("ml_org", 32'h100, 32'(middle_left_origin));
		wr(`DLFR_IDX_MR_MODE, {3'b110, 5'h0, w, 4'h0, h});
		pulse;
		chk("mr_frm", 32'h1, 32'(middle_right_frame));
		chk("mr_wid", {18'h0, w, 6'h0}, 32'(middle_right_width));
		chk("mr_hgt", 32'(h) + 1, 32'(middle_right_height));
		chk("mr_fmt", 32'h1, 32'(middle_right_pixel_format));
		// shown frames read back, a write there is ignored without error
		wr(`DLFR_IDX_STATUS, 32'hFFFFFFFF);
		rd(`DLFR_IDX_STATUS, 32'h00000002);
		$display("test flip done");
		// unmapped read and misaligned write are refused
		apb(1'b0, 12'hFFC, 32'h0, {2'b11, 32'h0});
		apb(1'b1, 12'h091, 32'h0, {2'b01, 32'h0});
		rd(`DLFR_IDX_CON_ORG, 32'h03FFFFF0);
		// reset in mid-run clears the bank
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`DLFR_IDX_CON_ORG, 32'h0);
		chk("ml_hgt", 32'h1, 32'(middle_left_height));
		$display("test refusal and reset done");
		stop_test;
	end
endmodule : dlfr_regs_bench

bind dlfr_regs dlfr_regs_asserts chk_u (.pclk, .presetn, .psel, .penable,
	.pready, .pslverr, .frame_boundary, .console_origin, .console_fetch,
	.console_pixel_format, .window_origin, .window_fetch,
	.window_memory_width, .middle_left_origin, .middle_left_width,
	.middle_left_height, .middle_left_frame);
